// [bench/frcv_props.sv]
`timescale 1ns/10ps
`default_nettype none
`include "frcv_defs.svh"
module frcv_props (
   input wire logic clk, // Clock
   input wire logic rst, // Async reset
   input wire logic scan_end, // End of scan
   input wire logic done, // Completion
   input wire logic abnormal, // Failed completion
   input wire logic [`FRCV_DATA_W-1:0] result, // Result word
   input wire logic [`FRCV_DATA_W-1:0] rx_count // Received count
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_close;
      done && scan_end ##1 !done;
   endsequence
   a_done_at_scan: assert property ($rose(done) |-> $past(scan_end))
      else $error("done rose away from scan end");
   a_done_holds: assert property (done && !scan_end |=> done)
      else $error("done fell inside its scan");
   a_done_falls: assert property (done && scan_end |-> s_close)
      else $error("done held past next scan end");
   a_abn_ok_low: assert property (done && result == `FRCV_RES_OK |-> !abnormal)
      else $error("abnormal set on success");
   a_abn_on_fail: assert property (done && result != `FRCV_RES_OK |-> abnormal)
      else $error("abnormal missing on failure");
   a_abn_in_done: assert property (abnormal |-> done)
      else $error("abnormal outside done");
   a_err_module: assert property (done && result != `FRCV_RES_OK |-> result >= 16'h7000)
      else $error("error code below module range");
   a_report_stable: assert property (done && !$rose(done) |-> $stable(result) && $stable(rx_count))
      else $error("report changed while done");
endmodule : frcv_props
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "frcv_defs.svh"
module tb;
   import frcv_pkg::*;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, slv;
   logic rx_valid, rx_ready, rx_chan, rx_last;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] rx_data;
   int n_errors = 0;
   int check_count = 0;
   int cyc = 0;
   frcv_if frcv_if_inst ();
   frcv_device frcv_device_inst (.clk(clk), .rst(rst), .link(frcv_if_inst.dev),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_chan(rx_chan), .rx_last(rx_last),
      .rx_data(rx_data));
   frcv_host frcv_host_inst (.clk(clk), .rst(rst), .link(frcv_if_inst.host), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   frcv_props frcv_props_inst (.clk(clk), .rst(rst), .scan_end(frcv_if_inst.scan_end),
      .done(frcv_if_inst.done), .abnormal(frcv_if_inst.abnormal),
      .result(frcv_if_inst.result), .rx_count(frcv_if_inst.rx_count));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic wrap_up();
      $display("Checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   // Hang guard, about three times the expected run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_errors++;
         wrap_up();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e,
         input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      chk(nm, e, q & m);
   endtask : rd
   // Channel two in byte units, channel one in words
   task automatic cmd(input logic [2:0] op, input logic [1:0] ch);
      apb(1'b1, 8'h00, {18'h0, 2'b10, 2'b00, ch, 1'b0, op, 3'b0, 1'b1});
   endtask : cmd
   task automatic wait_done(input logic abn);
      do apb(1'b0, 8'h08, 32'h0); while (q[1] !== 1'b1);
      chk("abnormal", {31'h0, abn}, {31'h0, q[2]});
      apb(1'b1, 8'h08, 32'h6);
   endtask : wait_done
   task automatic push(input logic ch, input logic [15:0] d, input logic l);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_chan <= ch;
      rx_data <= d;
      rx_last <= l;
      do @(posedge clk); while (rx_ready !== 1'b1);
      rx_valid <= 1'b0;
   endtask : push
   initial begin
      {psel, penable, pwrite, rx_valid, rx_chan, rx_last} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      rx_data = 16'h0000;
      rst = 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 8; i++) push(1'b0, 16'h00A0 + 16'(i), i == 7);
      repeat (2) @(posedge clk);
      chk("rx_ready full", 32'h0, {31'h0, rx_ready});
      rd(8'h08, "read_req one", 32'h8, 32'h18);
      apb(1'b1, 8'h04, 32'h2);
      cmd(3'h0, 2'h1);
      wait_done(1'b0);
      rd(8'h0C, "result one", 32'h1_0000, 32'h3_FFFF);
      rd(8'h10, "count one", 32'h2, 32'hFFFF);
      rd(8'h40, "word 0", 32'hA0, 32'hFFFF);
      rd(8'h44, "word 1", 32'hA1, 32'hFFFF);
      chk("rx_ready drained", 32'h1, {31'h0, rx_ready});
      rd(8'h20, "unmapped", 32'h0, 32'hFFFF_FFFF);
      chk("pslverr", 32'h1, {31'h0, slv});
      cmd(3'h0, 2'h3);
      rd(8'h08, "bad channel", 32'h0, 32'h1);
      apb(1'b1, 8'h04, 32'h0);
      cmd(3'h0, 2'h2);
      rd(8'h08, "zero allow", 32'h0, 32'h1);
      push(1'b1, 16'h0011, 1'b0);
      rd(8'h08, "read_req two", 32'h10, 32'h18);
      apb(1'b1, 8'h04, 32'h4);
      cmd(3'h0, 2'h2);
      // Repeat waits for a read request, then is taken and dropped
      cmd(3'h0, 2'h2);
      push(1'b1, 16'h0022, 1'b0);
      repeat (4000) @(posedge clk);
      rd(8'h08, "no report", 32'h40, 32'h63);
      cmd(3'h3, 2'h2);
      rd(8'h08, "buffered refused", 32'h0, 32'h1);
      // Buffered op skipped: channel two receive open
      for (int i = 1; i < 8; i++) if (i != 3) begin
         cmd(i[2:0], 2'h2);
         wait_done(1'b1);
         rd(8'h0C, "fail code", {14'h0, 2'h2, i < 3 ? 16'h7FF0 : 16'h7FF2}, 32'h3_FFFF);
      end
      push(1'b1, 16'h0033, 1'b1);
      wait_done(1'b0);
      rd(8'h0C, "result two", 32'h2_0000, 32'h3_FFFF);
      rd(8'h10, "count two", 32'h3, 32'hFFFF);
      rd(8'h40, "bytes 0", 32'h2211, 32'hFFFF);
      rd(8'h44, "bytes 1", 32'h33, 32'hFF);
      wrap_up();
   end
endmodule : tb
`default_nettype wire

// [common/frcv_defs.svh]
// What this block does
// - Host selects channel 1 or 2 only
// - Result word zero ok, else error
// - Count word holds received units, bytes or words
// - Host sets allowable count one or more
// - Received data copied in order from start
// - Excess data dropped, success, count equals allowable
// - Host issues receive as level request only
// - Host issues receive only while read-request set
// - Repeat receive on busy channel ignored
// - Settings during receive fails 7FF0H
// - Host avoids buffered receive on same channel
// - Later of receive and reinit fails 7FF0H
// - Other-protocol command on channel fails 7FF2H
// - Done rises at scan end, falls next
// - Abnormal flag stays low on success
// - Abnormal flag pulses one scan on failure
// - Module error codes at 7000H and above
`ifndef FRCV_DEFS_SVH
`define FRCV_DEFS_SVH
`define FRCV_DATA_W 16
`define FRCV_WORD_W 18
`define FRCV_ADDR_W 4
`define FRCV_FIFO_DEPTH 8
`define FRCV_RES_OK 16'h0000
`define FRCV_ERR_SIMUL 16'h7FF0
`define FRCV_ERR_PROTO 16'h7FF2
`define FRCV_CHAN_NONE 2'h0
`define FRCV_CHAN_ONE 2'h1
`define FRCV_CHAN_TWO 2'h2
`define FRCV_CLK_NS 8
`define FRCV_REINIT_NS 1000
`define FRCV_SCAN_NS 10000
`define FRCV_CNT_W 12
`define FRCV_A_CTRL 8'h00
`define FRCV_A_ALLOW 8'h04
`define FRCV_A_STATUS 8'h08
`define FRCV_A_RESULT 8'h0C
`define FRCV_A_COUNT 8'h10
`define FRCV_A_DEST 2'h1
`define FRCV_CTRL_GO 0
`define FRCV_CTRL_OP_LSB 4
`define FRCV_CTRL_CH_LSB 8
`define FRCV_CTRL_UNIT_LSB 12
`define FRCV_ST_BUSY 0
`define FRCV_ST_DONE 1
`define FRCV_ST_ABN 2
`endif

// [common/frcv_if.sv]
`timescale 1ns/10ps
`default_nettype none
`include "frcv_defs.svh"
interface frcv_if;
   import frcv_pkg::*;
   logic cmd_valid;
   frcv_op_t cmd_op;
   logic [1:0] cmd_chan;
   logic [`FRCV_DATA_W-1:0] cmd_allow;
   logic [1:0] unit_bytes;
   logic scan_end;
   logic cmd_ack;
   logic [1:0] read_req;
   logic done;
   logic abnormal;
   logic [1:0] done_chan;
   frcv_op_t done_op;
   logic [`FRCV_DATA_W-1:0] result;
   logic [`FRCV_DATA_W-1:0] rx_count;
   logic dest_we;
   logic [`FRCV_ADDR_W-1:0] dest_addr;
   logic [1:0] dest_be;
   logic [`FRCV_DATA_W-1:0] dest_data;
   modport dev (
      input cmd_valid, cmd_op, cmd_chan, cmd_allow, unit_bytes, scan_end,
      output cmd_ack, read_req, done, abnormal, done_chan, done_op, result, rx_count,
      output dest_we, dest_addr, dest_be, dest_data
   );
   modport host (
      output cmd_valid, cmd_op, cmd_chan, cmd_allow, unit_bytes, scan_end,
      input cmd_ack, read_req, done, abnormal, done_chan, done_op, result, rx_count,
      input dest_we, dest_addr, dest_be, dest_data
   );
endinterface : frcv_if
`default_nettype wire

// [common/frcv_pkg.sv]
package frcv_pkg;
   typedef enum logic [2:0] {
      receive_op,
      channel_settings_op,
      module_reinit_op,
      buffered_receive_op,
      on_demand_send_op,
      bidir_send_op,
      bidir_receive_op,
      predefined_protocol_op
   } frcv_op_t;
endpackage : frcv_pkg

// [verilog/frcv_device.sv]
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "frcv_defs.svh"
module frcv_device (
   input wire logic clk, // 125 MHz
   input wire logic rst, // Async, active high
   frcv_if.dev link, // Toward the host
   input wire logic rx_valid, // Received word offered
   output logic rx_ready, // Buffer has room
   input wire logic rx_chan, // 0 channel one, 1 channel two
   input wire logic rx_last, // Last word of message
   input wire logic [`FRCV_DATA_W-1:0] rx_data // Received unit
);
   import frcv_pkg::*;

   localparam int REINIT_CYC = (`FRCV_REINIT_NS + `FRCV_CLK_NS - 1) / `FRCV_CLK_NS;
   localparam int DW = `FRCV_DATA_W;

   logic [`FRCV_WORD_W-1:0] head;
   logic head_valid;
   logic [1:0] active_reg;
   logic [1:0] rpend_reg;
   logic [DW-1:0] allow_reg [2];
   logic [DW-1:0] cnt_reg [2];
   logic [DW-1:0] rres_reg [2];
   logic [DW-1:0] rcnt_reg [2];
   logic cpend_reg;
   logic [DW-1:0] cres_reg;
   frcv_op_t cop_reg;
   logic [1:0] cch_reg;
   logic [7:0] reinit_reg;
   logic reinit_fin_reg;
   logic taken_reg;
   logic ack_reg;
   logic [1:0] read_req_reg;
   logic done_reg;
   logic abn_reg;
   logic [1:0] done_ch_reg;
   frcv_op_t done_op_reg;
   logic [DW-1:0] result_reg;
   logic [DW-1:0] count_reg;
   logic dest_we_reg;
   logic [`FRCV_ADDR_W-1:0] dest_addr_reg;
   logic [1:0] dest_be_reg;
   logic [DW-1:0] dest_data_reg;
   logic [DW-1:0] cmd_res;
   wire head_take;

   // Receive path buffer
   frcv_fifo #(.WIDTH(`FRCV_WORD_W), .DEPTH(`FRCV_FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst(rst),
      .s_valid(rx_valid),
      .s_ready(rx_ready),
      .s_data({rx_chan, rx_last, rx_data}),
      .m_valid(head_valid),
      .m_ready(head_take),
      .m_data(head)
   );

   // Head word decode
   wire head_ch = head[`FRCV_WORD_W-1];
   wire head_last = head[DW];
   wire [DW-1:0] head_word = head[DW-1:0];
   wire [1:0] head_oh = {head_ch, !head_ch};
   wire head_bytes = link.unit_bytes[head_ch];
   wire [DW-1:0] cur_cnt = cnt_reg[head_ch];
   assign head_take = head_valid && active_reg[head_ch] && !rpend_reg[head_ch];
   wire store = head_take && (cur_cnt < allow_reg[head_ch]);
   wire fin = head_take && head_last;
   wire [DW-1:0] fin_cnt = cur_cnt + DW'(store);
   wire [1:0] fin_c = {2{fin}} & head_oh;

   // Command decode
   wire cmd_ch = link.cmd_chan == `FRCV_CHAN_TWO;
   wire [1:0] cmd_oh = {cmd_ch, !cmd_ch};
   wire is_rcv = link.cmd_op == receive_op;
   wire is_reinit = link.cmd_op == module_reinit_op;
   wire reinit_busy = reinit_reg != '0;
   wire ch_active = active_reg[cmd_ch];
   wire cmd_new = link.cmd_valid && !taken_reg && !cpend_reg && !rpend_reg[cmd_ch]
                  && (is_rcv || !reinit_busy);
   wire rcv_go = cmd_new && is_rcv && !ch_active;
   wire rcv_fail = rcv_go && reinit_busy;
   wire rcv_start = rcv_go && !reinit_busy;
   wire [1:0] start_c = {2{rcv_start}} & cmd_oh;
   wire [1:0] fail_c = {2{rcv_fail}} & cmd_oh;
   wire other_new = cmd_new && !is_rcv;
   wire reinit_go = other_new && is_reinit && cmd_res == `FRCV_RES_OK;

   always_comb begin
      unique case (link.cmd_op)
         channel_settings_op: cmd_res = ch_active ? `FRCV_ERR_SIMUL : `FRCV_RES_OK;
         module_reinit_op: cmd_res = (|active_reg) ? `FRCV_ERR_SIMUL : `FRCV_RES_OK;
         buffered_receive_op: cmd_res = `FRCV_RES_OK;
         receive_op: cmd_res = `FRCV_RES_OK;
         default: cmd_res = `FRCV_ERR_PROTO;
      endcase
   end

   // Completion reporter selection
   wire pick0 = rpend_reg[0];
   wire pick1 = !pick0 && rpend_reg[1];
   wire pickc = !(|rpend_reg) && cpend_reg;
   wire rep = link.scan_end && !done_reg;
   wire [1:0] rep_c = {2{rep}} & {pick1, pick0};
   wire [DW-1:0] sel_res = pick0 ? rres_reg[0] : (pick1 ? rres_reg[1] : cres_reg);
   wire [DW-1:0] sel_cnt = pick0 ? rcnt_reg[0] : (pick1 ? rcnt_reg[1] : '0);
   wire [1:0] sel_ch = pick0 ? `FRCV_CHAN_ONE : (pick1 ? `FRCV_CHAN_TWO : cch_reg);
   wire [DW-1:0] byte_addr = cur_cnt >> 1;

   genvar c;
   generate
      for (c = 0; c < 2; c++) begin : g_chan
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               active_reg[c] <= 1'b0;
               rpend_reg[c] <= 1'b0;
               allow_reg[c] <= '0;
               cnt_reg[c] <= '0;
               rres_reg[c] <= `FRCV_RES_OK;
               rcnt_reg[c] <= '0;
            end else begin
               if (start_c[c]) begin
                  active_reg[c] <= 1'b1;
                  allow_reg[c] <= link.cmd_allow;
                  cnt_reg[c] <= '0;
               end else if (fin_c[c]) begin
                  active_reg[c] <= 1'b0;
               end else if (store && head_oh[c]) begin
                  cnt_reg[c] <= fin_cnt;
               end
               if (fin_c[c]) begin
                  rpend_reg[c] <= 1'b1;
                  rres_reg[c] <= `FRCV_RES_OK;
                  rcnt_reg[c] <= fin_cnt;
               end else if (fail_c[c]) begin
                  rpend_reg[c] <= 1'b1;
                  rres_reg[c] <= `FRCV_ERR_SIMUL;
                  rcnt_reg[c] <= '0;
               end else if (rep_c[c]) begin
                  rpend_reg[c] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Non-receive command slot and reinit timer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cpend_reg <= 1'b0;
         cres_reg <= `FRCV_RES_OK;
         cop_reg <= receive_op;
         cch_reg <= `FRCV_CHAN_NONE;
         reinit_reg <= '0;
         reinit_fin_reg <= 1'b0;
      end else begin
         reinit_reg <= reinit_go ? 8'(REINIT_CYC) : (reinit_busy ? reinit_reg - 1'b1 : '0);
         reinit_fin_reg <= reinit_reg == 8'h01;
         if (other_new) begin
            cres_reg <= cmd_res;
            cop_reg <= link.cmd_op;
            cch_reg <= link.cmd_chan;
         end
         if (other_new && !reinit_go) begin
            cpend_reg <= 1'b1;
         end else if (reinit_fin_reg) begin
            cpend_reg <= 1'b1;
         end else if (rep && pickc) begin
            cpend_reg <= 1'b0;
         end
      end
   end

   // Request handshake and read-request status
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         taken_reg <= 1'b0;
         ack_reg <= 1'b0;
         read_req_reg <= '0;
      end else begin
         taken_reg <= link.cmd_valid && (taken_reg || cmd_new);
         ack_reg <= cmd_new;
         read_req_reg <= {2{head_valid}} & head_oh;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dest_we_reg <= 1'b0;
         dest_addr_reg <= '0;
         dest_be_reg <= '0;
         dest_data_reg <= '0;
      end else begin
         dest_we_reg <= store;
         dest_addr_reg <= head_bytes ? byte_addr[`FRCV_ADDR_W-1:0] : cur_cnt[`FRCV_ADDR_W-1:0];
         dest_be_reg <= !head_bytes ? 2'h3 : (cur_cnt[0] ? 2'h2 : 2'h1);
         dest_data_reg <= head_bytes ? {head_word[7:0], head_word[7:0]} : head_word;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done_reg <= 1'b0;
         abn_reg <= 1'b0;
         done_ch_reg <= `FRCV_CHAN_NONE;
         done_op_reg <= receive_op;
         result_reg <= `FRCV_RES_OK;
         count_reg <= '0;
      end else if (link.scan_end) begin
         if (done_reg) begin
            done_reg <= 1'b0;
            abn_reg <= 1'b0;
         end else if (pick0 || pick1 || pickc) begin
            done_reg <= 1'b1;
            abn_reg <= sel_res != `FRCV_RES_OK;
            done_ch_reg <= sel_ch;
            done_op_reg <= pickc ? cop_reg : receive_op;
            result_reg <= sel_res;
            count_reg <= sel_cnt;
         end
      end
   end

   assign link.cmd_ack = ack_reg;
   assign link.read_req = read_req_reg;
   assign link.done = done_reg;
   assign link.abnormal = abn_reg;
   assign link.done_chan = done_ch_reg;
   assign link.done_op = done_op_reg;
   assign link.result = result_reg;
   assign link.rx_count = count_reg;
   assign link.dest_we = dest_we_reg;
   assign link.dest_addr = dest_addr_reg;
   assign link.dest_be = dest_be_reg;
   assign link.dest_data = dest_data_reg;
endmodule : frcv_device
`default_nettype wire

// [verilog/frcv_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module frcv_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8
) (
   input wire logic clk, // Clock
   input wire logic rst, // Async reset
   input wire logic s_valid, // Write offer
   output logic s_ready, // Room left
   input wire logic [WIDTH-1:0] s_data, // Write data
   output logic m_valid, // Data present
   input wire logic m_ready, // Read take
   output logic [WIDTH-1:0] m_data // Head data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg, rd_reg;
   logic [AW:0] cnt_reg, cnt_next;
   logic ready_reg;
   wire push = s_valid && ready_reg;
   wire pop = m_valid && m_ready;
   assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
   assign m_valid = cnt_reg != '0;
   assign m_data = mem[rd_reg];
   assign s_ready = ready_reg;
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_reg] <= s_data;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         ready_reg <= 1'b0;
      end else begin
         wr_reg <= push ? wr_reg + 1'b1 : wr_reg;
         rd_reg <= pop ? rd_reg + 1'b1 : rd_reg;
         cnt_reg <= cnt_next;
         ready_reg <= cnt_next != (AW+1)'(DEPTH);
      end
   end
endmodule : frcv_fifo
`default_nettype wire

// [verilog/frcv_host.sv]
`timescale 1ns/10ps
`default_nettype none
`include "frcv_defs.svh"
module frcv_host (
   input wire logic clk, // 125 MHz
   input wire logic rst, // Async, active high
   frcv_if.host link, // Toward the module
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB write
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr // APB error
);
   import frcv_pkg::*;

   localparam int SCAN_CYC = `FRCV_SCAN_NS / `FRCV_CLK_NS;

   logic [`FRCV_DATA_W-1:0] dest_mem [2**`FRCV_ADDR_W];
   frcv_op_t op_reg;
   logic [1:0] ch_reg, unit_reg, rx_open_reg;
   logic [`FRCV_DATA_W-1:0] allow_reg, result_reg, count_reg;
   logic go_reg, valid_reg, done_st_reg, abn_st_reg, scan_reg, done_q_reg;
   logic [1:0] done_ch_reg;
   logic [`FRCV_CNT_W-1:0] scan_cnt_reg;
   logic [31:0] prdata_reg;
   logic pready_reg, pslverr_reg;

   // APB decode
   wire access = psel && penable && !pready_reg;
   wire wr_fire = psel && penable && pready_reg && pwrite;
   wire is_dest = paddr[7:6] == `FRCV_A_DEST;
   wire mapped = is_dest || paddr == `FRCV_A_CTRL || paddr == `FRCV_A_ALLOW
                 || paddr == `FRCV_A_STATUS || paddr == `FRCV_A_RESULT
                 || paddr == `FRCV_A_COUNT;
   wire wr_ctrl = wr_fire && paddr == `FRCV_A_CTRL;
   wire wr_stat = wr_fire && paddr == `FRCV_A_STATUS;
   wire [1:0] w_ch = pwdata[`FRCV_CTRL_CH_LSB +: 2];
   wire w_ch_hi = w_ch == `FRCV_CHAN_TWO;
   wire [2:0] w_op_bits = pwdata[`FRCV_CTRL_OP_LSB +: 3];
   wire w_rcv = w_op_bits == 3'(receive_op);
   wire w_buf = w_op_bits == 3'(buffered_receive_op);
   wire ch_ok = w_ch == `FRCV_CHAN_ONE || w_ch == `FRCV_CHAN_TWO;
   wire allow_ok = !w_rcv || allow_reg != '0;
   wire buf_ok = !w_buf || !rx_open_reg[w_ch_hi];
   wire go_ok = wr_ctrl && pwdata[`FRCV_CTRL_GO] && !go_reg && ch_ok && allow_ok && buf_ok;
   wire cur_hi = ch_reg == `FRCV_CHAN_TWO;
   wire may_send = op_reg != receive_op || link.read_req[cur_hi];
   // Done stands a whole scan, so act on its rise only
   wire done_rise = link.done && !done_q_reg;
   wire rcv_done = done_rise && link.done_op == receive_op;
   wire scan_wrap = scan_cnt_reg == `FRCV_CNT_W'(SCAN_CYC - 1);
   wire [31:0] status = {25'h0, rx_open_reg, link.read_req, abn_st_reg, done_st_reg, go_reg};
   wire [31:0] rd_mux = is_dest ? {16'h0, dest_mem[paddr[5:2]]} :
                        paddr == `FRCV_A_CTRL ? {18'h0, unit_reg, 2'h0, ch_reg, 1'b0,
                                                 op_reg, 4'h0} :
                        paddr == `FRCV_A_ALLOW ? {16'h0, allow_reg} :
                        paddr == `FRCV_A_STATUS ? status :
                        paddr == `FRCV_A_RESULT ? {14'h0, done_ch_reg, result_reg} :
                        paddr == `FRCV_A_COUNT ? {16'h0, count_reg} : 32'h0;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= '0;
      end else begin
         pready_reg <= access;
         pslverr_reg <= access && !mapped;
         prdata_reg <= access ? rd_mux : '0;
      end
   end

   always_ff @(posedge clk) begin
      if (link.dest_we && link.dest_be[0]) begin
         dest_mem[link.dest_addr][7:0] <= link.dest_data[7:0];
      end
      if (link.dest_we && link.dest_be[1]) begin
         dest_mem[link.dest_addr][15:8] <= link.dest_data[15:8];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         op_reg <= receive_op;
         ch_reg <= `FRCV_CHAN_ONE;
         unit_reg <= '0;
         allow_reg <= '0;
         go_reg <= 1'b0;
         valid_reg <= 1'b0;
      end else begin
         if (wr_ctrl && !go_reg) begin
            op_reg <= frcv_op_t'(w_op_bits);
            ch_reg <= w_ch;
            unit_reg <= pwdata[`FRCV_CTRL_UNIT_LSB +: 2];
         end
         if (wr_fire && paddr == `FRCV_A_ALLOW && !go_reg) begin
            allow_reg <= pwdata[`FRCV_DATA_W-1:0];
         end
         if (go_ok) begin
            go_reg <= 1'b1;
         end else if (valid_reg && link.cmd_ack) begin
            go_reg <= 1'b0;
         end
         valid_reg <= go_reg && !(valid_reg && link.cmd_ack) && (valid_reg || may_send);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done_st_reg <= 1'b0;
         abn_st_reg <= 1'b0;
         done_ch_reg <= `FRCV_CHAN_NONE;
         result_reg <= '0;
         count_reg <= '0;
         rx_open_reg <= '0;
         scan_cnt_reg <= '0;
         scan_reg <= 1'b0;
         done_q_reg <= 1'b0;
      end else begin
         done_q_reg <= link.done;
         done_st_reg <= done_rise || (done_st_reg && !(wr_stat && pwdata[`FRCV_ST_DONE]));
         abn_st_reg <= (done_rise && link.abnormal)
                       || (abn_st_reg && !(wr_stat && pwdata[`FRCV_ST_ABN]));
         if (link.done) begin
            done_ch_reg <= link.done_chan;
            result_reg <= link.result;
            count_reg <= link.rx_count;
         end
         for (int c = 0; c < 2; c++) begin
            if (valid_reg && link.cmd_ack && op_reg == receive_op && cur_hi == c[0]) begin
               rx_open_reg[c] <= 1'b1;
            end else if (rcv_done && link.done_chan == 2'(c + 1)) begin
               rx_open_reg[c] <= 1'b0;
            end
         end
         scan_reg <= scan_wrap;
         scan_cnt_reg <= scan_wrap ? '0 : scan_cnt_reg + 1'b1;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign link.cmd_valid = valid_reg;
   assign link.cmd_op = op_reg;
   assign link.cmd_chan = ch_reg;
   assign link.cmd_allow = allow_reg;
   assign link.unit_bytes = unit_reg;
   assign link.scan_end = scan_reg;
endmodule : frcv_host
`default_nettype wire
